// [bbnf_ctrl.sv]
// Byte-wide bus flash controller: registers, buffer, pin sequencer, parity hookup
`timescale 1ns/1ns
`default_nettype none
`include "bbnf_defs.svh"
module bbnf_ctrl
    import bbnf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] per_addr,
    input wire logic per_wr,
    input wire logic per_rd,
    input wire logic [15:0] per_wdata,
    output logic [15:0] per_rdata,
    input wire logic [7:0] nf_data_i,
    output logic [7:0] nf_data_o,
    output logic nf_data_oe,
    output logic nf_re_b,
    output logic nf_we_b,
    output logic nf_ce_b,
    output logic nf_irq
);
    // ************************************************************
    // Registers and decode
    // ************************************************************
    logic [8:0] ctrl_r;
    logic [4:0] pcnt_r;
    logic psrc_r;
    logic [4:0] pptr_r;
    logic pstart_r;
    logic pdir_r;
    logic [3:0] hptr_r;
    logic huse_r;
    logic hdir_r;
    logic eccen_r;
    logic eccrst_r;
    logic [15:0] dreg_r;
    logic hwr_pend_r;
    logic [15:0] pin_in_r;
    logic [15:0] buf_r [16];
    logic [7:0] din_s1_r;
    logic [7:0] din_s2_r;
    bbnf_pin_st_t st_r;
    bbnf_pin_st_t st_nxt;
    logic [5:0] wait_r;
    logic [5:0] wait_nxt;
    logic [4:0] pptr_nxt;
    logic [3:0] hptr_nxt;
    logic [15:0] dreg_nxt;
    logic [15:0] rd_mux;
    logic [15:0] rdata_r;
    logic [7:0] do_r;
    logic oe_r;
    logic re_b_r;
    logic we_b_r;
    logic ce_b_r;
    logic irq_r;
    logic done;
    logic byte_end;
    logic [17:0] lp;
    logic [5:0] cp;
    logic [7:0] ecnt;

    wire wr_ctrl = per_wr && (per_addr == `BBNF_OFF_CTRL);
    wire wr_data = per_wr && (per_addr == `BBNF_OFF_DATA);
    wire rd_data = per_rd && (per_addr == `BBNF_OFF_DATA);
    wire wr_pif = per_wr && (per_addr == `BBNF_OFF_PIF);
    wire wr_hif = per_wr && (per_addr == `BBNF_OFF_HIF);
    wire srst = ctrl_r[`BBNF_CTRL_SRST];
    wire ce_mode = ctrl_r[`BBNF_CTRL_CE_MODE];
    wire int_en = ctrl_r[`BBNF_CTRL_INT_EN];
    wire [5:0] ws = ctrl_r[`BBNF_CTRL_WS_HI:`BBNF_CTRL_WS_LO];
    wire go = (st_r == PS_IDLE) && pstart_r && !srst;
    wire cap = (st_r == PS_LOW) && (wait_r == `BBNF_ZERO6) && pdir_r && !srst;
    wire pin_buf_wr = cap && psrc_r;
    wire host_adv = huse_r && (hwr_pend_r || (rd_data && hdir_r));
    wire [15:0] wsrc_word = psrc_r ? buf_r[pptr_nxt[4:1]] : dreg_r;
    wire [7:0] wbyte = pptr_nxt[0] ? wsrc_word[7:0] : wsrc_word[15:8];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `BBNF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= per_wdata[8:0];
        end
    end

    // ************************************************************
    // Pin sequencer
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        wait_nxt = wait_r;
        done = 1'b0;
        byte_end = 1'b0;
        unique case (st_r)
            PS_IDLE: begin
                if (go) begin
                    st_nxt = PS_LOW;
                    wait_nxt = ws;
                end
            end
            PS_LOW: begin
                if (wait_r == `BBNF_ZERO6) begin
                    st_nxt = PS_HIGH;
                    wait_nxt = ws;
                end else begin
                    wait_nxt = wait_r - 6'h01;
                end
            end
            PS_HIGH: begin
                if (wait_r == `BBNF_ZERO6) begin
                    byte_end = 1'b1;
                    if (pcnt_r == `BBNF_ZERO5) begin
                        st_nxt = PS_IDLE;
                        done = 1'b1;
                    end else begin
                        st_nxt = PS_LOW;
                        wait_nxt = ws;
                    end
                end else begin
                    wait_nxt = wait_r - 6'h01;
                end
            end
        endcase
        if (srst) begin
            st_nxt = PS_IDLE;
            done = 1'b0;
            byte_end = 1'b0;
        end
    end

    assign pptr_nxt = byte_end ? pptr_r + 5'h01 : pptr_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= PS_IDLE;
            wait_r <= `BBNF_ZERO6;
        end else begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Writes during an operation are dropped to keep the burst coherent
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pcnt_r <= `BBNF_ZERO5;
            psrc_r <= 1'b0;
            pptr_r <= `BBNF_ZERO5;
            pstart_r <= 1'b0;
            pdir_r <= 1'b0;
        end else if (wr_pif && (st_r == PS_IDLE) && !srst) begin
            pcnt_r <= per_wdata[`BBNF_PIF_CNT_HI:`BBNF_PIF_CNT_LO];
            psrc_r <= per_wdata[`BBNF_PIF_SRC];
            pptr_r <= per_wdata[`BBNF_PIF_PTR_HI:`BBNF_PIF_PTR_LO];
            pstart_r <= per_wdata[`BBNF_PIF_START];
            pdir_r <= per_wdata[`BBNF_PIF_DIR];
        end else begin
            pptr_r <= pptr_nxt;
            if (byte_end && (pcnt_r != `BBNF_ZERO5)) begin
                pcnt_r <= pcnt_r - 5'h01;
            end
            if (done || srst) begin
                pstart_r <= 1'b0;
            end
        end
    end

    // Pins are async to clk: two stages before any use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_r <= `BBNF_ZERO8;
            din_s2_r <= `BBNF_ZERO8;
        end else begin
            din_s1_r <= nf_data_i;
            din_s2_r <= din_s1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            do_r <= `BBNF_ZERO8;
            oe_r <= 1'b0;
            re_b_r <= 1'b1;
            we_b_r <= 1'b1;
            ce_b_r <= 1'b1;
            irq_r <= 1'b0;
            pin_in_r <= `BBNF_ZERO16;
        end else begin
            if (st_nxt == PS_LOW && st_r != PS_LOW) begin
                do_r <= wbyte;
            end
            oe_r <= (st_nxt != PS_IDLE) && !pdir_r;
            re_b_r <= !((st_nxt == PS_LOW) && pdir_r);
            we_b_r <= !((st_nxt == PS_LOW) && !pdir_r);
            ce_b_r <= !((st_nxt != PS_IDLE) && (!ce_mode || st_nxt == PS_LOW));
            irq_r <= done && int_en;
            if (cap && !psrc_r) begin
                pin_in_r <= {pin_in_r[7:0], din_s2_r};
            end
        end
    end

    // ************************************************************
    // Buffer and data port
    // ************************************************************
    assign hptr_nxt = wr_hif ? per_wdata[`BBNF_HIF_PTR_HI:`BBNF_HIF_PTR_LO] :
                      host_adv ? hptr_r + 4'h1 : hptr_r;

    // Read mode follows the advanced pointer so back-to-back reads stay in step
    assign dreg_nxt = wr_data ? per_wdata :
                      !hdir_r ? dreg_r :
                      huse_r ? buf_r[hptr_nxt] : pin_in_r;

    always_ff @(posedge clk) begin
        if (pin_buf_wr && !pptr_r[0]) begin
            buf_r[pptr_r[4:1]][15:8] <= din_s2_r;
        end
        if (pin_buf_wr && pptr_r[0]) begin
            buf_r[pptr_r[4:1]][7:0] <= din_s2_r;
        end
        if (hwr_pend_r && huse_r) begin
            buf_r[hptr_r] <= dreg_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hptr_r <= `BBNF_ZERO4;
            huse_r <= 1'b0;
            hdir_r <= 1'b0;
            eccen_r <= 1'b0;
            eccrst_r <= 1'b0;
            dreg_r <= `BBNF_ZERO16;
            hwr_pend_r <= 1'b0;
        end else begin
            hptr_r <= hptr_nxt;
            if (wr_hif) begin
                huse_r <= per_wdata[`BBNF_HIF_USE];
                hdir_r <= per_wdata[`BBNF_HIF_DIR];
                eccen_r <= per_wdata[`BBNF_HIF_ECC_EN];
            end
            eccrst_r <= wr_hif && per_wdata[`BBNF_HIF_ECC_RST];
            dreg_r <= dreg_nxt;
            hwr_pend_r <= wr_data;
        end
    end

    bbnf_ecc u_ecc (
        .clk(clk),
        .rst_b(rst_b),
        .clr(eccrst_r || srst),
        .upd(eccen_r && (hwr_pend_r || rd_data)),
        .word(dreg_r),
        .line_parity(lp),
        .column_parity(cp),
        .word_cnt(ecnt)
    );

    // ************************************************************
    // Read-back
    // ************************************************************
    always_comb begin
        unique case (per_addr)
            `BBNF_OFF_CTRL: rd_mux = 16'(ctrl_r);
            `BBNF_OFF_LPL: rd_mux = lp[15:0];
            `BBNF_OFF_CPLPH: rd_mux = 16'({cp, lp[17:16]});
            `BBNF_OFF_DATA: rd_mux = dreg_r;
            `BBNF_OFF_PIF: rd_mux = 16'({pcnt_r, psrc_r, pptr_r, pstart_r, pdir_r});
            `BBNF_OFF_HIF: rd_mux = 16'({hptr_r, huse_r, hdir_r, eccen_r, eccrst_r});
            `BBNF_OFF_ECNT: rd_mux = 16'(ecnt);
            default: rd_mux = `BBNF_ZERO16;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= `BBNF_ZERO16;
        end else if (per_rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign per_rdata = rdata_r;
    assign nf_data_o = do_r;
    assign nf_data_oe = oe_r;
    assign nf_re_b = re_b_r;
    assign nf_we_b = we_b_r;
    assign nf_ce_b = ce_b_r;
    assign nf_irq = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [6:0] lo_len_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lo_len_r <= `BBNF_ZERO7;
        end else begin
            lo_len_r <= (st_r == PS_LOW) ? lo_len_r + 7'h01 : `BBNF_ZERO7;
        end
    end

    sequence s_last_byte;
        (st_r == PS_HIGH) && (wait_r == `BBNF_ZERO6) && (pcnt_r == `BBNF_ZERO5) && !srst;
    endsequence

    a_low_phase_len: assert property (
        (st_r == PS_HIGH) && ($past(st_r) == PS_LOW) && $stable(ws)
        |-> lo_len_r == 7'(ws) + 7'h01)
        else $error("strobe low phase length wrong");
    a_srst_abort: assert property (
        srst |=> (st_r == PS_IDLE) && !pstart_r && nf_re_b && nf_we_b)
        else $error("soft reset did not abort");
    a_done_irq: assert property (
        s_last_byte ##0 int_en |=> nf_irq ##1 !nf_irq)
        else $error("missing completion interrupt");
    a_start_clear: assert property (
        s_last_byte |=> !pstart_r && (st_r == PS_IDLE))
        else $error("start bit not cleared at end");
    a_ce_toggle: assert property (
        (st_r == PS_HIGH) && $past(ce_mode) |-> nf_ce_b)
        else $error("chip select low between bytes");
    a_read_src: assert property (
        hdir_r && !huse_r && !per_wr |=> dreg_r == $past(pin_in_r))
        else $error("data port not loaded from input register");
    a_ecc_clear: assert property (
        wr_hif && per_wdata[`BBNF_HIF_ECC_RST] |=> eccrst_r ##1 (!eccrst_r && ecnt == `BBNF_ZERO8))
        else $error("parity clear failed");
    a_cnt_write: assert property (
        wr_data && eccen_r && !wr_hif && !srst ##1 !eccrst_r && !rd_data && !srst
        |=> ecnt == $past(ecnt) + 8'h01)
        else $error("counter late after write");
    a_cnt_hold: assert property (
        !eccen_r && !eccrst_r && !srst |=> $stable(ecnt))
        else $error("counter moved while disabled");
endmodule // bbnf_ctrl
`default_nettype wire

// [bbnf_defs.svh]
// Register offsets, field positions and reset values of the byte-wide flash controller
`ifndef BBNF_DEFS_SVH
`define BBNF_DEFS_SVH

`define BBNF_OFF_CTRL 3'h0
`define BBNF_OFF_LPL 3'h1
`define BBNF_OFF_CPLPH 3'h2
`define BBNF_OFF_DATA 3'h3
`define BBNF_OFF_PIF 3'h4
`define BBNF_OFF_HIF 3'h5
`define BBNF_OFF_ECNT 3'h6

`define BBNF_CTRL_CE_MODE 8
`define BBNF_CTRL_INT_EN 7
`define BBNF_CTRL_SRST 6
`define BBNF_CTRL_WS_HI 5
`define BBNF_CTRL_WS_LO 0
`define BBNF_CTRL_RST 9'h000

`define BBNF_PIF_CNT_HI 12
`define BBNF_PIF_CNT_LO 8
`define BBNF_PIF_SRC 7
`define BBNF_PIF_PTR_HI 6
`define BBNF_PIF_PTR_LO 2
`define BBNF_PIF_START 1
`define BBNF_PIF_DIR 0

`define BBNF_HIF_PTR_HI 7
`define BBNF_HIF_PTR_LO 4
`define BBNF_HIF_USE 3
`define BBNF_HIF_DIR 2
`define BBNF_HIF_ECC_EN 1
`define BBNF_HIF_ECC_RST 0

`define BBNF_ZERO5 5'h00
`define BBNF_ZERO4 4'h0
`define BBNF_ZERO6 6'h00
`define BBNF_ZERO7 7'h00
`define BBNF_ZERO8 8'h00
`define BBNF_ZERO16 16'h0000
`define BBNF_ZERO18 18'h00000

`define BBNF_ADDR_BITS 9
`define BBNF_CP_M0 8'h55
`define BBNF_CP_M1 8'hAA
`define BBNF_CP_M2 8'h33
`define BBNF_CP_M3 8'hCC
`define BBNF_CP_M4 8'h0F
`define BBNF_CP_M5 8'hF0

`endif

// [bbnf_pkg.sv]
// Types shared by the byte-wide flash controller
package bbnf_pkg;
    typedef enum logic [1:0] {PS_IDLE, PS_LOW, PS_HIGH} bbnf_pin_st_t;
endpackage

// [bbnf_ecc.sv]
// Line and column parity generator over 16-bit data words
`timescale 1ns/1ns
`default_nettype none
`include "bbnf_defs.svh"
module bbnf_ecc
    import bbnf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic upd,
    input wire logic [15:0] word,
    output logic [17:0] line_parity,
    output logic [5:0] column_parity,
    output logic [7:0] word_cnt
);
    logic [17:0] lp_r;
    logic [5:0] cp_r;
    logic [7:0] cnt_r;
    logic [17:0] lp_nxt;
    logic [5:0] cp_nxt;
    logic [7:0] fold;

    // Each byte parity lands in the odd or even pair bit per address bit
    function automatic logic [17:0] lp_add(input logic [17:0] lp, input logic [8:0] a,
                                           input logic p);
        logic [17:0] r;
        r = lp;
        for (int k = 0; k < `BBNF_ADDR_BITS; k++) begin
            if (a[k]) begin
                r[2*k+1] = r[2*k+1] ^ p;
            end else begin
                r[2*k] = r[2*k] ^ p;
            end
        end
        return r;
    endfunction

    // High byte sits at the even byte address
    assign lp_nxt = lp_add(lp_add(lp_r, {cnt_r, 1'b0}, ^word[15:8]), {cnt_r, 1'b1}, ^word[7:0]);
    assign fold = word[15:8] ^ word[7:0];
    assign cp_nxt = cp_r ^ {^(fold & `BBNF_CP_M5), ^(fold & `BBNF_CP_M4), ^(fold & `BBNF_CP_M3),
                            ^(fold & `BBNF_CP_M2), ^(fold & `BBNF_CP_M1), ^(fold & `BBNF_CP_M0)};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lp_r <= `BBNF_ZERO18;
            cp_r <= `BBNF_ZERO6;
            cnt_r <= `BBNF_ZERO8;
        end else if (clr) begin
            lp_r <= `BBNF_ZERO18;
            cp_r <= `BBNF_ZERO6;
            cnt_r <= `BBNF_ZERO8;
        end else if (upd) begin
            lp_r <= lp_nxt;
            cp_r <= cp_nxt;
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign line_parity = lp_r;
    assign column_parity = cp_r;
    assign word_cnt = cnt_r;
endmodule // bbnf_ecc
`default_nettype wire

// [bbnf_flash_model.sv]
// Behavioural byte-wide flash device seen from the controller pins
`timescale 1ns/1ns
`default_nettype none
module bbnf_flash_model #(
    parameter int ACC_NS = 10
) (
    input wire logic [7:0] nf_data_o,
    input wire logic nf_data_oe,
    input wire logic nf_re_b,
    input wire logic nf_we_b,
    input wire logic nf_ce_b,
    output logic [7:0] nf_data_i
);
    logic [7:0] got[$];
    logic [7:0] rd_q[$];
    logic [7:0] last;
    logic sel;

    initial begin
        last = 8'h00;
        sel = 1'b0;
        nf_data_i = 8'hFF;
    end

    // Latch enables come from processor GPIO, only strobes and select are seen
    always @(negedge nf_we_b) begin
        #1;
        sel = (nf_ce_b === 1'b0);
    end

    always @(posedge nf_we_b) begin
        if (sel && nf_data_oe === 1'b1) begin
            got.push_back(nf_data_o);
        end
        sel = 1'b0;
    end

    always @(negedge nf_re_b) begin
        #(ACC_NS);
        if (nf_ce_b === 1'b0 && nf_re_b === 1'b0 && rd_q.size() > 0) begin
            last = rd_q.pop_front();
            nf_data_i = last;
        end
    end

    // Released bus shows the inverse so a late sample cannot pass by luck
    always @(posedge nf_re_b) begin
        nf_data_i = ~last;
    end
endmodule // bbnf_flash_model
`default_nettype wire

// [byte_bus_nand_flash_ctrl_tb.sv]
// Self-checking testbench of the byte-wide flash controller
`timescale 1ns/1ns
`default_nettype none
module byte_bus_nand_flash_ctrl_tb;
    import bbnf_pkg::*;
    typedef struct {logic [2:0] a; logic [15:0] w; logic [15:0] e;} bbnf_row_t;
    logic clk, rst_b, per_wr, per_rd, nf_data_oe, nf_re_b, nf_we_b, nf_ce_b, nf_irq;
    logic prev_low, busy;
    logic [2:0] per_addr;
    logic [15:0] per_wdata, per_rdata, d;
    logic [7:0] nf_data_i, nf_data_o;
    logic [15:0] q[$];
    logic [7:0] exp_b[6] = '{8'hA1, 8'h5C, 8'h3E, 8'h7D, 8'hC3, 8'hB4};
    logic [23:0] ecc;
    int n_mismatch, n_tests, n_irq, lo_run, hi_run, lo_len, hi_len, ce_up, ce_low;
    bbnf_row_t rows[9] = '{'{3'h1, 16'h1234, 16'h0000}, '{3'h2, 16'h00FF, 16'h0000},
        '{3'h6, 16'h00FF, 16'h0000}, '{3'h7, 16'hFFFF, 16'h0000},
        '{3'h4, 16'h1F7C, 16'h1F7C}, '{3'h4, 16'hE000, 16'h0000},
        '{3'h5, 16'h00FA, 16'h00FA}, '{3'h0, 16'hFE00, 16'h0000},
        '{3'h0, 16'h01BF, 16'h01BF}};

    bbnf_ctrl i_bbnf_ctrl (.clk(clk), .rst_b(rst_b), .per_addr(per_addr), .per_wr(per_wr),
        .per_rd(per_rd), .per_wdata(per_wdata), .per_rdata(per_rdata),
        .nf_data_i(nf_data_i), .nf_data_o(nf_data_o), .nf_data_oe(nf_data_oe),
        .nf_re_b(nf_re_b), .nf_we_b(nf_we_b), .nf_ce_b(nf_ce_b), .nf_irq(nf_irq));
    bbnf_flash_model i_bbnf_flash_model (.nf_data_o(nf_data_o), .nf_data_oe(nf_data_oe),
        .nf_re_b(nf_re_b), .nf_we_b(nf_we_b), .nf_ce_b(nf_ce_b), .nf_data_i(nf_data_i));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ********************************
    // Pin monitor
    // ********************************
    always @(negedge clk) begin
        if (nf_irq === 1'b1) n_irq++;
        if (nf_data_oe === 1'b1 && nf_ce_b === 1'b1) ce_up++;
        if (nf_data_oe === 1'b1 && nf_we_b === 1'b1 && nf_ce_b === 1'b0) ce_low++;
        if (nf_we_b === 1'b0 || nf_re_b === 1'b0) begin
            if (!prev_low) hi_len = hi_run;
            if (!prev_low) lo_run = 0;
            lo_run++;
            prev_low = 1'b1;
        end else begin
            if (prev_low) lo_len = lo_run;
            if (prev_low) hi_run = 0;
            hi_run++;
            prev_low = 1'b0;
        end
    end

    // ********************************
    // Bus tasks and helpers
    // ********************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_q(input logic [2:0] a, input logic [15:0] w[$]);
        foreach (w[i]) begin
            @(negedge clk);
            per_addr = a;
            per_wdata = w[i];
            per_wr = 1'b1;
        end
        @(negedge clk);
        per_wr = 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        logic [15:0] w[$];
        w.push_back(v);
        wr_q(a, w);
    endtask

    // Reads on n consecutive edges; now skips the lead-in edge
    task automatic rd_n(input logic [2:0] a, input int n, input bit now);
        q.delete();
        if (!now) @(negedge clk);
        per_addr = a;
        per_rd = 1'b1;
        repeat (n) begin
            @(negedge clk);
            q.push_back(per_rdata);
        end
        per_rd = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        rd_n(a, 1, 1'b0);
        d = q[0];
    endtask

    task automatic wait_idle;
        busy = 1'b1;
        for (int i = 0; i < 400 && busy; i++) begin
            rd(3'h4);
            busy = d[1];
        end
        chk("op busy", 16'h0000, {15'h0000, busy});
    endtask

    function automatic logic [23:0] ecc_of(input logic [7:0] b[$]);
        logic [17:0] lp = 18'h00000;
        logic [5:0] cp = 6'h00;
        logic [7:0] m[6] = '{8'h55, 8'hAA, 8'h33, 8'hCC, 8'h0F, 8'hF0};
        foreach (b[i]) begin
            for (int k = 0; k < 9; k++) lp[2 * k + i[k]] ^= ^b[i];
            for (int j = 0; j < 6; j++) cp[j] ^= ^(b[i] & m[j]);
        end
        return {cp, lp};
    endfunction

    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        end_of_test;
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        rst_b = 1'b0;
        per_addr = 3'h0;
        per_wr = 1'b0;
        per_rd = 1'b0;
        per_wdata = 16'h0000;
        prev_low = 1'b0;
        i_bbnf_flash_model.rd_q = '{8'h5A, 8'hC6, 8'h91, 8'hE2, 8'h6B, 8'h17};
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk("register", rows[i].e, d);
        end
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk("pins in reset", 16'h001C, {11'h000, nf_re_b, nf_we_b, nf_ce_b, nf_data_oe, nf_irq});
        rst_b = 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(a[2:0]);
            chk("reset value", 16'h0000, d);
        end
        // Buffered burst write, continuous select, two wait states
        wr(3'h5, 16'h0008);
        q = '{16'hA15C, 16'h3E7D};
        wr_q(3'h3, q);
        wr(3'h0, 16'h0082);
        ce_up = 0;
        wr(3'h4, 16'h0382);
        wait_idle;
        chk("low phase", 16'h0003, lo_len[15:0]);
        chk("high phase", 16'h0003, hi_len[15:0]);
        chk("select gaps", 16'h0000, ce_up[15:0]);
        chk("irq count", 16'h0001, n_irq[15:0]);
        // Data port source, toggled select, no wait states
        wr(3'h3, 16'hC3B4);
        wr(3'h0, 16'h0180);
        ce_low = 0;
        ce_up = 0;
        wr(3'h4, 16'h0102);
        wait_idle;
        chk("low phase", 16'h0001, lo_len[15:0]);
        chk("high phase", 16'h0001, hi_len[15:0]);
        chk("select in high", 16'h0000, ce_low[15:0]);
        chk("select toggles", 16'h0001, {15'h0000, ce_up > 0});
        chk("irq count", 16'h0002, n_irq[15:0]);
        chk("bytes sent", 16'h0006, i_bbnf_flash_model.got.size());
        foreach (exp_b[i]) chk("pin byte", {8'h00, exp_b[i]}, {8'h00, i_bbnf_flash_model.got[i]});
        // Burst read into buffer words 4 and 5, interrupt masked
        wr(3'h0, 16'h0003);
        wr(3'h4, 16'h03A3);
        wait_idle;
        chk("irq masked", 16'h0002, n_irq[15:0]);
        wr(3'h5, 16'h0001);
        wr(3'h5, 16'h004E);
        rd_n(3'h3, 2, 1'b0);
        chk("first word", 16'h5AC6, q[0]);
        chk("second word", 16'h91E2, q[1]);
        ecc = ecc_of('{8'h5A, 8'hC6, 8'h91, 8'hE2});
        rd(3'h6);
        chk("ecc count", 16'h0002, d);
        rd(3'h1);
        chk("line parity low", ecc[15:0], d);
        rd(3'h2);
        chk("column parity", {8'h00, ecc[23:16]}, d);
        wr(3'h5, 16'h004C);
        rd(3'h3);
        rd(3'h6);
        chk("ecc count off", 16'h0002, d);
        wr(3'h5, 16'h0000);
        wr(3'h3, 16'hFFFF);
        wr(3'h5, 16'h004C);
        rd(3'h3);
        chk("buffer kept", 16'h5AC6, d);
        wr(3'h5, 16'h0001);
        rd(3'h6);
        chk("ecc count clear", 16'h0000, d);
        rd(3'h1);
        chk("parity clear", 16'h0000, d);
        // Port writes feed the parity one clock later
        wr(3'h5, 16'h0002);
        wr(3'h3, 16'h1234);
        ecc = ecc_of('{8'h12, 8'h34});
        rd(3'h6);
        chk("ecc write count", 16'h0001, d);
        rd(3'h1);
        chk("write parity", ecc[15:0], d);
        rd(3'h2);
        chk("write column", {8'h00, ecc[23:16]}, d);
        // Read into the input register instead of the buffer
        wr(3'h5, 16'h0004);
        wr(3'h4, 16'h0103);
        wait_idle;
        rd(3'h3);
        chk("input register", 16'h6B17, d);
        // Long write aborted by soft reset
        wr(3'h0, 16'h003F);
        wr(3'h4, 16'h1F82);
        repeat (20) @(negedge clk);
        wr(3'h4, 16'h0000);
        rd(3'h4);
        chk("start while busy", 16'h0002, d & 16'h0002);
        wr(3'h0, 16'h0040);
        rd(3'h4);
        chk("start after abort", 16'h0000, d & 16'h0002);
        chk("pins after abort", 16'h0002, {14'h0000, nf_we_b, nf_data_oe});
        wr(3'h0, 16'h0000);
        end_of_test;
    end
endmodule // byte_bus_nand_flash_ctrl_tb
`default_nettype wire
